// ===== design/timer8_two_compare_units.sv
`timescale 1ns/1ns
// Functional notes
// - counter and both compare values are 8-bit CPU read/write registers.
// - counter value zero is bottom.
// - counter value 0xff is the maximum.
// - top is the maximum or compare value A, depending on mode.
// - timer clock from prescaler or external pin, chosen by clock select.
// - clock select zero stops all timer-clock activity.
// - CPU reads and writes the counter at any time.
// - a CPU counter write beats a coincident count or clear.
// - each timer clock clears, increments or decrements per waveform mode.
// - overflow flag set at the mode's point; it can request an interrupt.
// - counter is compared with both compare values continuously.
// - compare flag sets one timer clock after the match.
// - enabled flag requests an interrupt; service clears the flag.
// - writing one clears a flag; writing zero does nothing.
// - three flags in one register, each gated by its own mask bit.
// - in PWM modes CPU accesses the compare buffer.
// - buffer moves to active compare only at top of the sequence.
// - in normal and CTC modes compare writes take effect at once.
// - force strobe in non-PWM modes acts on the output like a match.
// - a forced compare sets no flag and leaves the counter alone.
// - a counter write blocks matches for the next timer clock.
// - output waveform uses match, mode, output mode, top and bottom.
module timer8_two_compare_units
  import timer8_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              ext_count_input,
  input  wire logic [2:0]        irq_ack,
  output logic [2:0]             irq_req,
  output logic                   compare_out_a,
  output logic                   compare_out_b
);

  state_s                        state_reg;
  state_s                        state_next;

  logic                          aw_hs;
  logic                          w_hs;
  logic                          ar_hs;
  logic                          do_wr;
  logic [ADDR_W-1:0]             wa;
  logic [7:0]                    wd;
  logic                          wl;
  logic                          tick;
  logic                          pwm;
  logic                          fast;
  logic                          top_ocra;
  logic [7:0]                    top_val;
  logic                          at_top;
  logic                          cnt_wr;
  logic [1:0]                    match;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    unique case (a[5:2])
      OFF_CONTROL_A[5:2], OFF_CONTROL_B[5:2], OFF_CONTROL_C[5:2],
      OFF_COUNT[5:2], OFF_COMPARE_A[5:2], OFF_COMPARE_B[5:2],
      OFF_IRQ_FLAG[5:2], OFF_IRQ_MASK[5:2], OFF_POWER[5:2]: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                  input logic [5:0]        off);
    wr_hit = (a[5:2] == off[5:2]);
  endfunction

  function automatic logic [7:0] read_byte(input state_s           s,
                                           input logic [ADDR_W-1:0] a);
    logic                        p;
    p = s.wgm[0];
    read_byte = REG_RESET;
    unique case (a[5:2])
      OFF_CONTROL_A[5:2]: read_byte = {s.com[0], s.com[1], 2'h0, s.wgm[1:0]};
      OFF_CONTROL_B[5:2]: read_byte = {4'h0, s.wgm[2], s.cs};
      OFF_COUNT[5:2]:     read_byte = s.cnt;
      OFF_COMPARE_A[5:2]: read_byte = p ? s.buff[0] : s.ocr[0];
      OFF_COMPARE_B[5:2]: read_byte = p ? s.buff[1] : s.ocr[1];
      OFF_IRQ_FLAG[5:2]:  read_byte = {5'h0, s.flags};
      OFF_IRQ_MASK[5:2]:  read_byte = {5'h0, s.mask};
      OFF_POWER[5:2]:     read_byte = {7'h0, s.pwr_off};
      default:            read_byte = REG_RESET;
    endcase
  endfunction

  // action on the output latch for a non-PWM match or forced compare
  function automatic logic plain_action(input logic [1:0] com,
                                        input logic       cur);
    unique case (com)
      COM_TOGGLE: plain_action = ~cur;
      COM_CLEAR:  plain_action = 1'b0;
      COM_SET:    plain_action = 1'b1;
      default:    plain_action = cur;
    endcase
  endfunction

  assign aw_hs    = awvalid & state_reg.awready;
  assign w_hs     = wvalid & state_reg.wready;
  assign ar_hs    = arvalid & state_reg.arready;
  assign wa       = aw_hs ? awaddr : state_reg.waddr;
  assign wd       = w_hs ? wdata[7:0] : state_reg.wbyte;
  assign wl       = w_hs ? wstrb[0] : state_reg.wlane;
  assign do_wr    = (state_reg.aw_got | aw_hs) & (state_reg.w_got | w_hs)
                    & ~state_reg.bvalid;
  assign cnt_wr   = do_wr & wl & wr_hit(wa, OFF_COUNT);

  // timer clock enable: prescaler taps or synchronised pin edges
  always_comb begin
    unique case (state_reg.cs)
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (state_reg.pre[2:0] == 3'h0);
      CS_DIV64:    tick = (state_reg.pre[5:0] == 6'h00);
      CS_DIV256:   tick = (state_reg.pre[7:0] == 8'h00);
      CS_DIV1024:  tick = (state_reg.pre == 10'h000);
      CS_EXT_FALL: tick = state_reg.ext_s3 & ~state_reg.ext_s2;
      CS_EXT_RISE: tick = ~state_reg.ext_s3 & state_reg.ext_s2;
      default:     tick = 1'b0;
    endcase
    if (state_reg.pwr_off) begin
      tick = 1'b0;
    end
  end

  assign pwm      = state_reg.wgm[0];
  assign fast     = state_reg.wgm[1] & state_reg.wgm[0];
  assign top_ocra = state_reg.wgm[2] | (state_reg.wgm == WGM_CTC);
  assign top_val  = top_ocra ? state_reg.ocr[0] : CNT_MAX;
  assign at_top   = (state_reg.cnt == top_val);

  for (genvar i = 0; i < 2; i++) begin : g_cmp
    // equality compare, masked for one timer clock after a counter write
    assign match[i] = (state_reg.cnt == state_reg.ocr[i])
                      & ~state_reg.blk;
  end

  always_comb begin
    logic [2:0]                  set_f;
    logic [2:0]                  clr_f;
    logic                        ovf;
    logic                        bottom;
    state_next = state_reg;
    set_f      = 3'h0;
    clr_f      = irq_ack;
    ovf        = 1'b0;
    bottom     = (state_reg.cnt == CNT_BOTTOM);

    state_next.pre    = PRE_W'(state_reg.pre + 10'h001);
    state_next.ext_s1 = ext_count_input;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.ext_s3 = state_reg.ext_s2;

    // write channel: address and data accepted in either order
    if (aw_hs) begin
      state_next.aw_got = 1'b1;
      state_next.waddr  = awaddr;
    end
    if (w_hs) begin
      state_next.w_got = 1'b1;
      state_next.wbyte = wdata[7:0];
      state_next.wlane = wstrb[0];
    end
    if (do_wr) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    state_next.awready = ~state_next.aw_got & ~state_next.bvalid;
    state_next.wready  = ~state_next.w_got & ~state_next.bvalid;

    // read channel
    if (ar_hs) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      state_next.rdata  = {24'h0, read_byte(state_reg, araddr)};
    end else if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = ~state_next.rvalid;

    // counter sequence on each timer clock
    if (tick) begin
      if (pwm && !fast) begin
        if (state_reg.up) begin
          if (at_top) begin
            state_next.up  = 1'b0;
            state_next.cnt = 8'(state_reg.cnt - CNT_ONE);
          end else begin
            state_next.cnt = 8'(state_reg.cnt + CNT_ONE);
          end
        end else if (bottom) begin
          state_next.up  = 1'b1;
          state_next.cnt = 8'(state_reg.cnt + CNT_ONE);
          ovf            = 1'b1;
        end else begin
          state_next.cnt = 8'(state_reg.cnt - CNT_ONE);
        end
      end else if (fast || state_reg.wgm == WGM_CTC) begin
        state_next.up  = 1'b1;
        state_next.cnt = at_top ? CNT_BOTTOM
                                : 8'(state_reg.cnt + CNT_ONE);
        ovf            = fast ? at_top : (state_reg.cnt == CNT_MAX);
      end else begin
        state_next.up  = 1'b1;
        state_next.cnt = 8'(state_reg.cnt + CNT_ONE);
        ovf            = (state_reg.cnt == CNT_MAX);
      end
      state_next.blk = 1'b0;
    end

    for (int i = 0; i < 2; i++) begin
      // flag and waveform action at the timer clock after the match
      if (tick && match[i]) begin
        set_f[i+1] = 1'b1;
        if (!pwm) begin
          state_next.oc[i] = plain_action(state_reg.com[i],
                                          state_reg.oc[i]);
        end else if (state_reg.com[i] == COM_TOGGLE) begin
          if (i == 0 && state_reg.wgm[2]) begin
            state_next.oc[i] = ~state_reg.oc[i];
          end
        end else if (state_reg.com[i] != COM_NONE) begin
          // non-inverting clears on the up match, inverting sets
          state_next.oc[i] = (state_reg.com[i] == COM_SET)
                             ^ (!fast && !state_reg.up);
        end
      end
      // fast PWM: output restored when the counter wraps to bottom
      if (tick && fast && at_top && state_reg.com[i][1]) begin
        state_next.oc[i] = ~state_reg.com[i][0];
      end
      // double buffer update at top of the sequence
      if (tick && pwm && at_top && (fast || state_reg.up)) begin
        state_next.ocr[i] = state_reg.buff[i];
      end
    end
    set_f[FLAG_OVF_BIT] = ovf;

    // register writes
    if (do_wr && wl) begin
      if (wr_hit(wa, OFF_CONTROL_A)) begin
        state_next.com[0]     = wd[COM_A_LSB +: 2];
        state_next.com[1]     = wd[COM_B_LSB +: 2];
        state_next.wgm[1:0]   = wd[WGM_LO_LSB +: 2];
      end
      if (wr_hit(wa, OFF_CONTROL_B)) begin
        state_next.wgm[2]     = wd[WGM_HI_BIT];
        state_next.cs         = wd[CS_LSB +: 3];
      end
      if (wr_hit(wa, OFF_CONTROL_C) && !pwm) begin
        // forced compare touches only the output latch
        if (wd[FORCE_A_BIT]) begin
          state_next.oc[0] = plain_action(state_reg.com[0],
                                          state_next.oc[0]);
        end
        if (wd[FORCE_B_BIT]) begin
          state_next.oc[1] = plain_action(state_reg.com[1],
                                          state_next.oc[1]);
        end
      end
      if (cnt_wr) begin
        state_next.cnt = wd;
        state_next.blk = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (wr_hit(wa, i == 0 ? OFF_COMPARE_A : OFF_COMPARE_B)) begin
          state_next.buff[i] = wd;
          if (!pwm) begin
            state_next.ocr[i] = wd;
          end
        end
      end
      if (wr_hit(wa, OFF_IRQ_FLAG)) begin
        clr_f = clr_f | wd[2:0];
      end
      if (wr_hit(wa, OFF_IRQ_MASK)) begin
        state_next.mask = wd[2:0];
      end
      if (wr_hit(wa, OFF_POWER)) begin
        state_next.pwr_off = wd[POWER_OFF_BIT];
      end
    end

    // a new event outweighs a clear in the same cycle
    state_next.flags = (state_reg.flags & ~clr_f) | set_f;
    state_next.irq   = state_next.flags & state_next.mask;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg         <= '0;
      state_reg.up      <= 1'b1;
      state_reg.awready <= 1'b1;
      state_reg.wready  <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign awready       = state_reg.awready;
  assign wready        = state_reg.wready;
  assign bvalid        = state_reg.bvalid;
  assign bresp         = state_reg.bresp;
  assign arready       = state_reg.arready;
  assign rvalid        = state_reg.rvalid;
  assign rresp         = state_reg.rresp;
  assign rdata         = state_reg.rdata;
  assign irq_req       = state_reg.irq;
  assign compare_out_a = state_reg.oc[0];
  assign compare_out_b = state_reg.oc[1];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_cnt_write_wins: assert property (
    cnt_wr |=> state_reg.cnt == $past(wd))
    else $error("counter write lost to count");

  a_stopped_holds: assert property (
    (state_reg.cs == CS_STOP && !cnt_wr) |=> $stable(state_reg.cnt))
    else $error("stopped counter moved");

  a_power_off_holds: assert property (
    (state_reg.pwr_off && !cnt_wr) |=> $stable(state_reg.cnt))
    else $error("powered-off counter moved");

  a_flag_after_match: assert property (
    (tick && match[0]) |=> state_reg.flags[FLAG_A_BIT])
    else $error("compare flag not set after match");

  a_block_after_write: assert property (
    (tick && state_reg.blk && state_reg.flags[2:1] == 2'h0)
      |=> state_reg.flags[2:1] == 2'h0)
    else $error("match not blocked after counter write");

  a_force_no_flag: assert property (
    (do_wr && wl && wr_hit(wa, OFF_CONTROL_C) && !tick && !cnt_wr)
      |=> state_reg.flags[2:1] == $past(state_reg.flags[2:1] & ~irq_ack[2:1])
          && state_reg.cnt == $past(state_reg.cnt))
    else $error("forced compare touched flag or counter");

  a_normal_overflow: assert property (
    (state_reg.wgm == WGM_NORMAL && tick && state_reg.cnt == CNT_MAX
      && !cnt_wr) |=> state_reg.cnt == CNT_BOTTOM
                      && state_reg.flags[FLAG_OVF_BIT])
    else $error("normal mode overflow wrong");

  a_ctc_clears: assert property (
    (state_reg.wgm == WGM_CTC && tick && at_top && !cnt_wr)
      |=> state_reg.cnt == CNT_BOTTOM)
    else $error("clear on match failed");

  a_w1c_clears: assert property (
    (do_wr && wl && wr_hit(wa, OFF_IRQ_FLAG) && wd[FLAG_A_BIT]
      && !(tick && match[0])) |=> !state_reg.flags[FLAG_A_BIT])
    else $error("write one did not clear flag");

  a_pwm_buffered: assert property (
    (pwm && !(tick && at_top)) |=> state_reg.ocr == $past(state_reg.ocr))
    else $error("active compare changed outside top");

  a_irq_gating: assert property (
    irq_req == (state_reg.flags & state_reg.mask))
    else $error("interrupt not gated by mask");

endmodule // timer8_two_compare_units

// ===== design/timer8_pkg.sv
package timer8_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam int unsigned    ADDR_W         = 6;
  localparam logic [5:0]     OFF_CONTROL_A  = 6'h00;
  localparam logic [5:0]     OFF_CONTROL_B  = 6'h04;
  localparam logic [5:0]     OFF_CONTROL_C  = 6'h08;
  localparam logic [5:0]     OFF_COUNT      = 6'h0c;
  localparam logic [5:0]     OFF_COMPARE_A  = 6'h10;
  localparam logic [5:0]     OFF_COMPARE_B  = 6'h14;
  localparam logic [5:0]     OFF_IRQ_FLAG   = 6'h18;
  localparam logic [5:0]     OFF_IRQ_MASK   = 6'h1c;
  localparam logic [5:0]     OFF_POWER      = 6'h20;

  // field positions
  localparam int unsigned    COM_A_LSB      = 6;
  localparam int unsigned    COM_B_LSB      = 4;
  localparam int unsigned    WGM_LO_LSB     = 0;
  localparam int unsigned    WGM_HI_BIT     = 3;
  localparam int unsigned    CS_LSB         = 0;
  localparam int unsigned    FORCE_A_BIT    = 7;
  localparam int unsigned    FORCE_B_BIT    = 6;
  localparam int unsigned    FLAG_OVF_BIT   = 0;
  localparam int unsigned    FLAG_A_BIT     = 1;
  localparam int unsigned    FLAG_B_BIT     = 2;
  localparam int unsigned    POWER_OFF_BIT  = 0;

  // counter limits and reset values
  localparam logic [7:0]     CNT_BOTTOM     = 8'h00;
  localparam logic [7:0]     CNT_MAX        = 8'hff;
  localparam logic [7:0]     CNT_ONE        = 8'h01;
  localparam logic [7:0]     REG_RESET      = 8'h00;

  // clock select codes
  localparam logic [2:0]     CS_STOP        = 3'h0;
  localparam logic [2:0]     CS_DIV1        = 3'h1;
  localparam logic [2:0]     CS_DIV8        = 3'h2;
  localparam logic [2:0]     CS_DIV64       = 3'h3;
  localparam logic [2:0]     CS_DIV256      = 3'h4;
  localparam logic [2:0]     CS_DIV1024     = 3'h5;
  localparam logic [2:0]     CS_EXT_FALL    = 3'h6;
  localparam logic [2:0]     CS_EXT_RISE    = 3'h7;
  localparam int unsigned    PRE_W          = 10;

  // waveform modes
  localparam logic [2:0]     WGM_NORMAL     = 3'h0;
  localparam logic [2:0]     WGM_CTC        = 3'h2;

  // compare output mode codes
  localparam logic [1:0]     COM_NONE       = 2'h0;
  localparam logic [1:0]     COM_TOGGLE     = 2'h1;
  localparam logic [1:0]     COM_CLEAR      = 2'h2;
  localparam logic [1:0]     COM_SET        = 2'h3;

  localparam logic [1:0]     RESP_OKAY      = 2'h0;
  localparam logic [1:0]     RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    logic                    aw_got;
    logic                    w_got;
    logic [ADDR_W-1:0]       waddr;
    logic [7:0]              wbyte;
    logic                    wlane;
    logic [1:0][1:0]         com;
    logic [2:0]              wgm;
    logic [2:0]              cs;
    logic                    pwr_off;
    logic [7:0]              cnt;
    logic                    up;
    logic                    blk;
    logic [1:0][7:0]         ocr;
    logic [1:0][7:0]         buff;
    logic [2:0]              flags;
    logic [2:0]              mask;
    logic [2:0]              irq;
    logic [1:0]              oc;
    logic [PRE_W-1:0]        pre;
    logic                    ext_s1;
    logic                    ext_s2;
    logic                    ext_s3;
  } state_s;

endpackage

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
  import timer8_pkg::*;

  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = '0;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b0;
  logic              ext_count_input = 1'b0;
  logic [2:0]        irq_ack = '0;
  logic [2:0]        irq_req;
  logic              compare_out_a;
  logic              compare_out_b;
  int                mismatches = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  logic [1:0]        resp;
  logic [31:0]       data;
  logic [7:0]        com_code [4] = '{8'h40, 8'h80, 8'hc0, 8'h00};
  logic              out_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  timer8_two_compare_units u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ext_count_input(ext_count_input), .irq_ack(irq_ack),
    .irq_req(irq_req), .compare_out_a(compare_out_a),
    .compare_out_b(compare_out_b)
  );

  always #50 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one write, address and data offered together
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    logic got;
    aw = 1'b0;
    w = 1'b0;
    got = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      if (aw && w && bvalid === 1'b1) begin
        got = 1'b1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    logic took;
    took = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!(took && rvalid === 1'b1)) begin
      @(posedge aclk);
      if (!took && arready === 1'b1) begin
        took = 1'b1;
        arvalid <= 1'b0;
      end
    end
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    rd(a);
    check(data, {24'h0, e});
  endtask

  // let the timer tick on every aclk for a while, then stop it
  task automatic run(input int n);
    wr(OFF_CONTROL_B, {5'h0, CS_DIV1});
    repeat (n) @(posedge aclk);
    wr(OFF_CONTROL_B, {5'h0, CS_STOP});
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(OFF_COUNT, 8'h00);
    rd_chk(OFF_COMPARE_A, 8'h00);
    rd_chk(OFF_IRQ_FLAG, 8'h00);
    wr(OFF_COMPARE_A, 8'ha5);
    wr(OFF_COMPARE_B, 8'h5a);
    wr(OFF_COUNT, 8'h3c);
    rd_chk(OFF_COMPARE_A, 8'ha5);
    rd_chk(OFF_COMPARE_B, 8'h5a);
    repeat (20) @(posedge aclk);
    rd_chk(OFF_COUNT, 8'h3c);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    wr(6'h24, 8'hff);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    rd_chk(6'h24, 8'h00);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    // compare a match, masked request, clears
    wr(OFF_COMPARE_A, 8'h40);
    wr(OFF_COUNT, 8'h30);
    wr(OFF_IRQ_MASK, 8'h02);
    run(20);
    rd_chk(OFF_IRQ_FLAG, 8'h02);
    check({29'h0, irq_req}, 32'h2);
    wr(OFF_IRQ_FLAG, 8'h00);
    rd_chk(OFF_IRQ_FLAG, 8'h02);
    irq_ack <= 3'b010;
    @(posedge aclk);
    irq_ack <= 3'b000;
    rd_chk(OFF_IRQ_FLAG, 8'h00);
    // overflow through the maximum
    wr(OFF_COUNT, 8'hf0);
    wr(OFF_IRQ_MASK, 8'h07);
    run(30);
    rd_chk(OFF_IRQ_FLAG, 8'h01);
    check({29'h0, irq_req}, 32'h1);
    wr(OFF_IRQ_MASK, 8'h06);
    @(posedge aclk);
    check({29'h0, irq_req}, 32'h0);
    wr(OFF_IRQ_FLAG, 8'h01);
    rd_chk(OFF_IRQ_FLAG, 8'h00);
    // counter write equal to compare value blocks the match
    wr(OFF_COMPARE_B, 8'h20);
    wr(OFF_COUNT, 8'h20);
    run(5);
    rd_chk(OFF_IRQ_FLAG, 8'h00);
    wr(OFF_COUNT, 8'h1f);
    run(5);
    rd_chk(OFF_IRQ_FLAG, 8'h04);
    wr(OFF_IRQ_FLAG, 8'h07);
    // forced compare with every output mode
    wr(OFF_COUNT, 8'h77);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CONTROL_A, com_code[i] | (com_code[i] >> 2));
      wr(OFF_CONTROL_C, 8'hc0);
      repeat (2) @(posedge aclk);
      check({31'h0, compare_out_a}, {31'h0, out_exp[i]});
      check({31'h0, compare_out_b}, {31'h0, out_exp[i]});
    end
    rd_chk(OFF_IRQ_FLAG, 8'h00);
    rd_chk(OFF_COUNT, 8'h77);
    // fast pwm: write lands in buffer, active value still matches
    wr(OFF_CONTROL_A, 8'h03);
    wr(OFF_COMPARE_B, 8'h60);
    rd_chk(OFF_COMPARE_B, 8'h60);
    wr(OFF_COUNT, 8'h1e);
    run(10);
    rd_chk(OFF_IRQ_FLAG, 8'h04);
    // fast pwm output: clear on match, set at wrap, buffer loads at top
    wr(OFF_IRQ_FLAG, 8'h07);
    wr(OFF_CONTROL_A, 8'h83);
    wr(OFF_COUNT, 8'h3e);
    run(40);
    check({31'h0, compare_out_a}, 32'h0);
    wr(OFF_COUNT, 8'hfd);
    run(5);
    check({31'h0, compare_out_a}, 32'h1);
    rd_chk(OFF_IRQ_FLAG, 8'h03);
    wr(OFF_IRQ_FLAG, 8'h07);
    wr(OFF_COUNT, 8'h5e);
    run(5);
    rd_chk(OFF_IRQ_FLAG, 8'h04);
    // phase correct: turns at top, overflow at bottom
    wr(OFF_CONTROL_A, 8'h01);
    wr(OFF_IRQ_FLAG, 8'h07);
    wr(OFF_COUNT, 8'hfd);
    run(5);
    rd_chk(OFF_COUNT, 8'hf9);
    wr(OFF_COUNT, 8'h02);
    run(5);
    rd_chk(OFF_COUNT, 8'h06);
    rd_chk(OFF_IRQ_FLAG, 8'h01);
    // clear on match with compare value a as top
    wr(OFF_CONTROL_A, 8'h02);
    wr(OFF_COMPARE_A, 8'h04);
    wr(OFF_IRQ_FLAG, 8'h07);
    wr(OFF_COUNT, 8'h00);
    run(5);
    rd_chk(OFF_COUNT, 8'h03);
    rd_chk(OFF_IRQ_FLAG, 8'h02);
    // power-off bit halts the counter
    wr(OFF_POWER, 8'h01);
    run(5);
    rd_chk(OFF_COUNT, 8'h03);
    wr(OFF_POWER, 8'h00);
    // external pin, rising edges counted
    wr(OFF_CONTROL_A, 8'h00);
    wr(OFF_COUNT, 8'h10);
    wr(OFF_CONTROL_B, {5'h0, CS_EXT_RISE});
    repeat (3) begin
      ext_count_input <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_count_input <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    wr(OFF_CONTROL_B, {5'h0, CS_STOP});
    rd_chk(OFF_COUNT, 8'h13);
    summarize();
  end
endmodule // tb
